// [rtl/pseq_pkg.sv]
// Shared constants of the power sequencer configuration block
package pseq_pkg;
   localparam int NREG = 19;
   localparam int IX_W = 5;
   localparam int IX_BOOT = 0;
   localparam int IX_TIMING = 1;
   localparam int IX_L12 = 2;
   localparam int IX_L34 = 3;
   localparam int IX_B12 = 4;
   localparam int IX_B34 = 5;
   localparam int IX_PLO = 6;
   localparam int IX_PHI = 7;
   localparam int IX_RST = 8;
   localparam int IX_VB2 = 9;
   localparam int IX_VB1 = 10;
   localparam int IX_VB4 = 11;
   localparam int IX_VB3 = 12;
   localparam int IX_VL1 = 13;
   localparam int IX_VL2 = 14;
   localparam int IX_VL3 = 15;
   localparam int IX_VL4 = 16;
   localparam int IX_BBAT = 17;
   localparam int IX_STAT = 18;
   // Byte offsets, index 0 rightmost
   localparam logic [NREG-1:0][7:0] REG_OFS = {
      8'hF0, 8'hC5, 8'hAC, 8'hAB, 8'hAA, 8'hA9, 8'hA7, 8'hA5, 8'hA4, 8'hA3,
      8'h99, 8'h96, 8'h95, 8'h8A, 8'h89, 8'h84, 8'h83, 8'h82, 8'h10};
   // Start-up image, stands in for the one-time-programmable contents
   localparam logic [NREG-1:0][7:0] REG_RST = {
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h04, 8'h0F, 8'hE1, 8'h87, 8'h65, 8'h43, 8'h21, 8'h11, 8'h01};
   localparam int AUTO_BOOT_BIT = 0;
   localparam int NIB_W = 4;
   localparam int LO_LSB = 0;
   localparam int HI_LSB = 4;
   localparam int RST_SEL_BIT = 0;
   localparam int RST_DLY_LSB = 2;
   localparam int RST_DLY_W = 6;
   localparam int STAT_LVL_LSB = 4;
   localparam int NRG = 8;
   // Regulators 0..3 linear 1..4, 4..7 buck 1..4
   localparam int SLOT_IX [NRG] = '{IX_L12, IX_L12, IX_L34, IX_L34,
                                    IX_B12, IX_B12, IX_B34, IX_B34};
   localparam int CLK_NS = 25;
   localparam int SLOT_UNIT_NS = 32000;
   localparam int SLOT_UNIT_CYC = (SLOT_UNIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int RST_UNIT_NS = 1000000;
   localparam int RST_UNIT_CYC = (RST_UNIT_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [2:0] {PS_OFF, PS_DUMMY, PS_UP, PS_ACTIVE, PS_DOWN} pseq_state_t;
endpackage

// [rtl/pseq_unit_timer.sv]
// Countdown timer in whole units of a fixed cycle count
`timescale 1ns/1ps
`default_nettype none
module pseq_unit_timer #(
   parameter int UNIT_CYC = 1280,
   parameter int N_W = 5
) (
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic start_in,
   input wire logic [N_W-1:0] units_in,
   output logic done_out
);
   localparam int P_W = $clog2(UNIT_CYC + 1);
   localparam logic [P_W-1:0] PRE_TOP = P_W'(UNIT_CYC - 1);
   typedef struct packed {
      logic busy;
      logic [P_W-1:0] pre;
      logic [N_W-1:0] units;
   } pseq_tmr_st_t;
   pseq_tmr_st_t q, d;

   always_comb begin
      d = q;
      done_out = q.busy && (q.pre == '0) && (q.units == '0);
      // A new start overrides a count in flight
      if (start_in) begin
         d.busy = 1'b1;
         d.pre = PRE_TOP;
         d.units = units_in - N_W'(1);
      end else if (q.busy) begin
         if (q.pre != '0) begin
            d.pre = q.pre - P_W'(1);
         end else if (q.units != '0) begin
            d.units = q.units - N_W'(1);
            d.pre = PRE_TOP;
         end else begin
            d.busy = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule // pseq_unit_timer
`default_nettype wire

// [rtl/pseq_i2c_slave.sv]
// Two-wire serial register port: address byte, register pointer, data
`timescale 1ns/1ps
`default_nettype none
module pseq_i2c_slave #(
   parameter logic [6:0] DEV_ADDR = 7'h2A
) (
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   output logic [7:0] rd_addr_out,
   input wire logic [7:0] rd_data_in,
   output logic wr_stb_out,
   output logic [7:0] wr_addr_out,
   output logic [7:0] wr_data_out
);
   typedef enum logic [2:0] {I_IDLE, I_DEV, I_REG, I_WR, I_RD} pseq_i2c_ph_t;
   typedef struct packed {
      logic scl1, scl2, scl3, sda1, sda2, sda3;
      pseq_i2c_ph_t ph;
      logic [3:0] bitc;
      logic [7:0] sh;
      logic rd, nack, oe, stb;
      logic [7:0] ptr, waddr, wdata;
   } pseq_i2c_st_t;
   pseq_i2c_st_t q, d;
   logic rise, fall, start, stop;

   assign sda_out = 1'b0;
   assign sda_oe_out = q.oe;
   assign rd_addr_out = q.ptr;
   assign wr_stb_out = q.stb;
   assign wr_addr_out = q.waddr;
   assign wr_data_out = q.wdata;

   always_comb begin
      d = q;
      d.scl1 = scl_in;
      d.scl2 = q.scl1;
      d.scl3 = q.scl2;
      d.sda1 = sda_in;
      d.sda2 = q.sda1;
      d.sda3 = q.sda2;
      d.stb = 1'b0;
      rise = q.scl2 & ~q.scl3;
      fall = ~q.scl2 & q.scl3;
      start = q.scl2 & q.scl3 & q.sda3 & ~q.sda2;
      stop = q.scl2 & q.scl3 & ~q.sda3 & q.sda2;
      if (start) begin
         d.ph = I_DEV;
         d.bitc = '0;
         d.oe = 1'b0;
      end else if (stop) begin
         d.ph = I_IDLE;
         d.oe = 1'b0;
      end else if (q.ph != I_IDLE && rise) begin
         if (q.bitc < 4'd8) begin
            d.sh = {q.sh[6:0], q.sda2};
         end else begin
            d.nack = q.sda2;
         end
         d.bitc = q.bitc + 4'd1;
      end else if (q.ph != I_IDLE && fall) begin
         if (q.bitc == 4'd8) begin
            // Acknowledge slot: slave drives for writes, releases for reads
            d.oe = 1'b1;
            unique case (q.ph)
               I_DEV: begin
                  d.rd = q.sh[0];
                  if (q.sh[7:1] != DEV_ADDR) begin
                     d.ph = I_IDLE;
                     d.oe = 1'b0;
                  end
               end
               I_REG: d.ptr = q.sh;
               I_WR: begin
                  d.stb = 1'b1;
                  d.waddr = q.ptr;
                  d.wdata = q.sh;
                  d.ptr = q.ptr + 8'd1;
               end
               default: begin
                  d.oe = 1'b0;
                  d.ptr = q.ptr + 8'd1;
               end
            endcase
         end else if (q.bitc == 4'd9) begin
            d.bitc = '0;
            d.oe = 1'b0;
            if (q.ph == I_DEV) begin
               d.ph = q.rd ? I_RD : I_REG;
            end else if (q.ph == I_REG) begin
               d.ph = I_WR;
            end
            if ((q.ph == I_DEV && q.rd) || (q.ph == I_RD && !q.nack)) begin
               d.ph = I_RD;
               d.sh = rd_data_in;
               d.oe = ~rd_data_in[7];
            end else if (q.ph == I_RD) begin
               d.ph = I_IDLE;
            end
         end else if (q.ph == I_RD) begin
            // Every rise shifts the byte up, so the next bit is always on top
            d.oe = ~q.sh[7];
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         q <= '0;
         q.scl1 <= 1'b1;
         q.scl2 <= 1'b1;
         q.scl3 <= 1'b1;
         q.sda1 <= 1'b1;
         q.sda2 <= 1'b1;
         q.sda3 <= 1'b1;
      end else begin
         q <= d;
      end
   end
endmodule // pseq_i2c_slave
`default_nettype wire

// [rtl/pseq_top.sv]
// Start-up sequencer configuration registers and slot sequencer
// Notes on behaviour
// (RL1) Boot bit picks direct power-up or powerdown waiting for button press.
// (RL2) Each buck voltage register sets its own buck converter target.
// (RL3) Each linear voltage register sets its own linear regulator target.
// (RL4) Software uses only the A voltage settings; B settings stay unused.
// (RL5) Timing register holds slot period and dummy slot period fields.
// (RL6) Each regulator has a slot field, two packed per register.
// (RL7) Slot zero means not sequenced; that regulator stays off.
// (RL8) Software keeps partial-down < system-end < power-end < max-count.
// (RL9) Basic setup: system-end pointer one, power-end pointer fourteen.
// (RL10) Basic setup: max-count pointer fifteen, partial-down pointer zero.
// (RL11) Reset output releases after chosen delay from a selectable start.
// (RL12) Backup battery register holds charge voltage and charge current.
// (RL13) Slots advance one per period; up ascending, down descending.
`timescale 1ns/1ps
`default_nettype none
module pseq_top
   import pseq_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2A,
   parameter int RST_UNIT = RST_UNIT_CYC
) (
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic power_button_input_n_in,
   output logic reset_output_n_out,
   output logic [3:0] linreg_en_out,
   output logic [3:0] buck_en_out,
   output logic [7:0] buck1_voltage_out,
   output logic [7:0] buck2_voltage_out,
   output logic [7:0] buck3_voltage_out,
   output logic [7:0] buck4_voltage_out,
   output logic [7:0] linreg1_voltage_out,
   output logic [7:0] linreg2_voltage_out,
   output logic [7:0] linreg3_voltage_out,
   output logic [7:0] linreg4_voltage_out,
   output logic [3:0] backup_charge_voltage_out,
   output logic [3:0] backup_charge_current_out
);
   typedef struct packed {
      logic [NREG-1:0][7:0] regs;
      pseq_state_t st;
      logic [3:0] level;
      logic boot_pend;
      logic btn1, btn2, btn3;
      logic rst_n;
      logic rst_wait;
      logic [NRG-1:0] en;
   } pseq_top_st_t;
   pseq_top_st_t q, d;

   logic [7:0] rd_addr, rd_data, wr_addr, wr_data;
   logic wr_stb, wr_hit, rd_hit;
   logic [IX_W-1:0] wr_ix, rd_ix;
   logic slot_go, slot_done, rst_go, rst_done, press;
   logic [NIB_W:0] slot_units;
   logic [RST_DLY_W:0] rst_units;
   logic [NIB_W-1:0] sys_end, pwr_end, partial_down_pointer, max_cnt;
   logic [NRG-1:0] en_nx, nz_mask;
   logic auto_boot, rst_sel;

   pseq_i2c_slave #(
      .DEV_ADDR(DEV_ADDR)
   ) u_port (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe_out(sda_oe_out),
      .rd_addr_out(rd_addr),
      .rd_data_in(rd_data),
      .wr_stb_out(wr_stb),
      .wr_addr_out(wr_addr),
      .wr_data_out(wr_data)
   );

   pseq_unit_timer #(
      .UNIT_CYC(SLOT_UNIT_CYC),
      .N_W(NIB_W + 1)
   ) u_slot_tmr (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .start_in(slot_go),
      .units_in(slot_units),
      .done_out(slot_done)
   );

   pseq_unit_timer #(
      .UNIT_CYC(RST_UNIT),
      .N_W(RST_DLY_W + 1)
   ) u_rst_tmr (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .start_in(rst_go),
      .units_in(rst_units),
      .done_out(rst_done)
   );

   // Offset to register index; unmapped offsets read zero, writes dropped
   function automatic logic [IX_W:0] find_ix(input logic [7:0] a);
      logic [IX_W:0] r;
      r = '0;
      for (int i = 0; i < NREG; i++) begin
         if (REG_OFS[i] == a) begin
            r = {1'b1, IX_W'(i)};
         end
      end
      return r;
   endfunction

   assign {wr_hit, wr_ix} = find_ix(wr_addr);
   assign {rd_hit, rd_ix} = find_ix(rd_addr);
   assign rd_data = rd_hit ? q.regs[rd_ix] : 8'h00;

   assign auto_boot = q.regs[IX_BOOT][AUTO_BOOT_BIT]; // RL1
   assign sys_end = q.regs[IX_PLO][LO_LSB +: NIB_W];
   assign pwr_end = q.regs[IX_PLO][HI_LSB +: NIB_W];
   assign max_cnt = q.regs[IX_PHI][LO_LSB +: NIB_W];
   assign partial_down_pointer = q.regs[IX_PHI][HI_LSB +: NIB_W];
   assign rst_sel = q.regs[IX_RST][RST_SEL_BIT];
   assign rst_units = {1'b0, q.regs[IX_RST][RST_DLY_LSB +: RST_DLY_W]} + 7'd1; // RL11

   // Even regulator in the low nibble, odd one in the high nibble
   for (genvar i = 0; i < NRG; i++) begin : g_reg
      logic [NIB_W-1:0] slot;
      assign slot = q.regs[SLOT_IX[i]][(i % 2) * NIB_W +: NIB_W]; // RL6
      assign nz_mask[i] = slot != '0;
      assign en_nx[i] = nz_mask[i] && (slot <= q.level); // RL7
   end

   always_comb begin
      d = q;
      slot_go = 1'b0;
      rst_go = 1'b0;
      slot_units = {1'b0, q.regs[IX_TIMING][LO_LSB +: NIB_W]} + 5'd1; // RL5
      d.btn1 = power_button_input_n_in;
      d.btn2 = q.btn1;
      d.btn3 = q.btn2;
      press = q.btn3 & ~q.btn2;
      d.boot_pend = 1'b0;
      if (wr_stb && wr_hit && (wr_ix != IX_W'(IX_STAT))) begin
         d.regs[wr_ix] = wr_data; // RL2 RL3 RL12
      end
      unique case (q.st)
         PS_OFF: begin
            if (q.boot_pend ? auto_boot : press) begin // RL1
               d.st = PS_DUMMY;
               slot_go = 1'b1;
               slot_units = {1'b0, q.regs[IX_TIMING][HI_LSB +: NIB_W]} + 5'd1; // RL5
            end
         end
         PS_DUMMY: begin
            if (slot_done) begin
               d.st = PS_UP;
               d.level = 4'd1;
               slot_go = 1'b1;
            end
         end
         PS_UP: begin
            if (slot_done) begin
               if (q.level >= pwr_end || q.level >= max_cnt) begin
                  d.st = PS_ACTIVE;
               end else begin
                  d.level = q.level + 4'd1; // RL13
                  slot_go = 1'b1;
               end
            end
         end
         PS_ACTIVE: begin
            if (press) begin
               d.st = PS_DOWN;
               d.rst_n = 1'b0;
               d.rst_wait = 1'b0;
               slot_go = 1'b1;
            end
         end
         PS_DOWN: begin
            if (slot_done) begin
               if ({1'b0, q.level} <= {1'b0, partial_down_pointer} + 5'd1) begin
                  d.level = partial_down_pointer;
                  d.st = PS_OFF;
               end else begin
                  d.level = q.level - 4'd1; // RL13
                  slot_go = 1'b1;
               end
            end
         end
      endcase
      // Delay starts at the system-end slot or on entering active
      if (!q.rst_n && !q.rst_wait && (d.st == PS_UP || d.st == PS_ACTIVE) &&
          (rst_sel ? (d.st == PS_ACTIVE) : (d.level >= sys_end))) begin
         rst_go = 1'b1; // RL11
         d.rst_wait = 1'b1;
      end
      // A press may land on the release cycle; power-down must win
      if (q.rst_wait && rst_done && d.st != PS_DOWN) begin
         d.rst_wait = 1'b0;
         d.rst_n = 1'b1; // RL11
      end
      d.en = en_nx; // RL13
      d.regs[IX_STAT] = {q.level, 1'b0, q.st};
   end

   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         q <= '0;
         q.regs <= REG_RST;
         q.boot_pend <= 1'b1;
         q.btn1 <= 1'b1;
         q.btn2 <= 1'b1;
         q.btn3 <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign reset_output_n_out = q.rst_n;
   assign linreg_en_out = q.en[3:0];
   assign buck_en_out = q.en[7:4];
   assign buck1_voltage_out = q.regs[IX_VB1]; // RL2
   assign buck2_voltage_out = q.regs[IX_VB2];
   assign buck3_voltage_out = q.regs[IX_VB3];
   assign buck4_voltage_out = q.regs[IX_VB4];
   assign linreg1_voltage_out = q.regs[IX_VL1]; // RL3
   assign linreg2_voltage_out = q.regs[IX_VL2];
   assign linreg3_voltage_out = q.regs[IX_VL3];
   assign linreg4_voltage_out = q.regs[IX_VL4];
   assign backup_charge_voltage_out = q.regs[IX_BBAT][HI_LSB +: NIB_W]; // RL12
   assign backup_charge_current_out = q.regs[IX_BBAT][LO_LSB +: NIB_W];

   // Checking aids: cycles since last slot start and expected length
   logic [19:0] gap_q, exp_q;
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         gap_q <= '0;
         exp_q <= '0;
      end else if (slot_go) begin
         gap_q <= 20'd1;
         exp_q <= 20'(slot_units) * 20'(SLOT_UNIT_CYC);
      end else begin
         gap_q <= gap_q + 20'd1;
      end
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (srst_in);

   // Boot choice and wake from powerdown
   auto_boot_a: assert property ( // RL1
      q.st == PS_OFF && q.boot_pend && auto_boot
      |=> q.st == PS_DUMMY ##1 q.st == PS_DUMMY) else $error("auto boot did not start");
   boot_wait_a: assert property ( // RL1
      q.st == PS_OFF && !q.boot_pend && !press
      |=> q.st == PS_OFF) else $error("powerdown left without a press");
   press_wake_a: assert property ( // RL1
      q.st == PS_OFF && !q.boot_pend && press
      |=> q.st == PS_DUMMY) else $error("press did not wake");

   // Register writes reach the regulator outputs
   buck_volt_a: assert property ( // RL2
      wr_stb && wr_hit && wr_ix == IX_W'(IX_VB1)
      |=> buck1_voltage_out == $past(wr_data)) else $error("buck1 voltage not written");
   lin_volt_a: assert property ( // RL3
      wr_stb && wr_hit && wr_ix == IX_W'(IX_VL4)
      |=> linreg4_voltage_out == $past(wr_data)) else $error("linreg4 voltage not written");

   // Lengths are latched at slot start, so a mid-slot write cannot skew them
   slot_time_a: assert property ( // RL5
      slot_done |-> gap_q == exp_q) else $error("slot length wrong");
   slot_zero_a: assert property ( // RL7
      (q.en & ~$past(nz_mask)) == '0) else $error("unsequenced regulator on");
   up_step_a: assert property ( // RL13
      q.st == PS_UP && slot_done && q.level < pwr_end && q.level < max_cnt
      |=> q.level == $past(q.level) + 4'd1 ##1 q.en == $past(en_nx))
      else $error("power-up step wrong");
   down_step_a: assert property ( // RL13
      q.st == PS_DOWN && slot_done && {1'b0, q.level} > {1'b0, partial_down_pointer} + 5'd1
      |=> q.level == $past(q.level) - 4'd1) else $error("power-down step wrong");

   // Reset output
   rst_release_a: assert property ( // RL11
      $rose(q.rst_n) |-> $past(rst_done) && $past(q.rst_wait))
      else $error("reset released early");
   rst_drop_a: assert property ( // RL11
      q.st == PS_ACTIVE && press |=> !reset_output_n_out)
      else $error("reset not reasserted");
   rst_hold_a: assert property ( // RL11
      q.st == PS_DOWN |-> !reset_output_n_out) else $error("reset released in power-down");

   bbat_set_a: assert property ( // RL12
      wr_stb && wr_hit && wr_ix == IX_W'(IX_BBAT)
      |=> {backup_charge_voltage_out, backup_charge_current_out} == $past(wr_data))
      else $error("backup charge not written");

   // Scenarios worth seeing
   boot_c: cover property (q.st == PS_UP ##1 q.st == PS_ACTIVE);
   rel_c: cover property ($rose(reset_output_n_out));
   down_c: cover property (q.st == PS_DOWN ##1 q.st == PS_OFF);
   wake_c: cover property (q.st == PS_OFF && !q.boot_pend && press);
   rst_go_c: cover property (rst_go);
endmodule // pseq_top
`default_nettype wire

// [bench/pmic_power_sequence_config_tb_top.sv]
// Self-checking bench for the sequencer configuration block
`timescale 1ns/1ps
`default_nettype none
module pmic_power_sequence_config_tb_top;
   import pseq_pkg::*;
   localparam int RSTU = 20;
   localparam int LIMIT = 95000;
   localparam logic [6:0] ADDR = 7'h2A;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic scl = 1'b1;
   logic sda_m = 1'b1;
   logic btn_n = 1'b1;
   wire logic sda_w;
   logic sda_do, sda_oe, rst_n;
   logic [3:0] ldo_en, bk_en, bv, bi;
   logic [7:0] vb [4];
   logic [7:0] vl [4];
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   int rel0 = 0;

   // Open drain: the slave can only pull the line low
   assign sda_w = sda_m & ~sda_oe;

   pseq_top #(.DEV_ADDR(ADDR), .RST_UNIT(RSTU)) DUT (
      .mclk_in(mclk), .srst_in(srst), .scl_in(scl), .sda_in(sda_w),
      .sda_out(sda_do), .sda_oe_out(sda_oe), .power_button_input_n_in(btn_n),
      .reset_output_n_out(rst_n), .linreg_en_out(ldo_en), .buck_en_out(bk_en),
      .buck1_voltage_out(vb[0]), .buck2_voltage_out(vb[1]),
      .buck3_voltage_out(vb[2]), .buck4_voltage_out(vb[3]),
      .linreg1_voltage_out(vl[0]), .linreg2_voltage_out(vl[1]),
      .linreg3_voltage_out(vl[2]), .linreg4_voltage_out(vl[3]),
      .backup_charge_voltage_out(bv), .backup_charge_current_out(bi));

   initial begin
      forever #12.5 mclk = ~mclk;
   end

   task automatic tally_and_finish();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc >= LIMIT) begin
         n_errors = n_errors + 1;
         tally_and_finish();
      end
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic hlf();
      repeat (5) @(negedge mclk);
   endtask

   task automatic wait_until(input int n);
      while (cyc - rel0 < n) @(negedge mclk);
   endtask

   // Data only moves well inside the low phase, clear of the falling edge
   task automatic clk_bit(input logic b, output logic s);
      repeat (2) @(negedge mclk);
      sda_m = b;
      hlf();
      scl = 1'b1;
      hlf();
      s = sda_w;
      scl = 1'b0;
   endtask

   task automatic i2c_start();
      sda_m = 1'b1;
      hlf();
      scl = 1'b1;
      hlf();
      sda_m = 1'b0;
      hlf();
      scl = 1'b0;
   endtask

   task automatic i2c_stop();
      repeat (2) @(negedge mclk);
      sda_m = 1'b0;
      hlf();
      scl = 1'b1;
      hlf();
      sda_m = 1'b1;
      hlf();
   endtask

   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
      clk_bit(1'b1, s);
      ack = ~s;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      logic ack;
      i2c_start();
      wr_byte({ADDR, 1'b0}, ack);
      wr_byte(a, ack);
      wr_byte(d, ack);
      check("write ack", {7'h00, ack}, 8'h01);
      i2c_stop();
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      logic ack;
      logic s;
      i2c_start();
      wr_byte({ADDR, 1'b0}, ack);
      wr_byte(a, ack);
      i2c_start();
      wr_byte({ADDR, 1'b1}, ack);
      check("read ack", {7'h00, ack}, 8'h01);
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
      clk_bit(1'b1, s);
      i2c_stop();
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      reg_rd(a, d);
      check(what, d, exp);
   endtask

   // Start-up image boots straight up; regulators follow their slots
   task automatic t_power_up();
      logic [8:0] on;
      for (int k = 0; k <= 8; k++) begin
         wait_until(2560 * k + 1280);
         on = (9'h001 << k) - 9'h001;
         check("linreg enables", {4'h0, ldo_en}, {4'h0, on[3:0]});
         check("buck enables", {4'h0, bk_en}, {4'h0, on[7:4]});
         if (k == 0) begin
            wait_until(2590);
            check("reset early", {7'h00, rst_n}, 8'h00);
            wait_until(2620);
            check("reset released", {7'h00, rst_n}, 8'h01);
         end
      end
      wait_until(38600);
      rd_chk("status active", 8'hF0, 8'hE3);
   endtask

   task automatic t_regs();
      logic ack;
      logic [7:0] vofs [8] = '{8'hA4, 8'hA3, 8'hA7, 8'hA5, 8'hA9, 8'hAA, 8'hAB, 8'hAC};
      for (int i = 0; i < NREG - 1; i++) rd_chk("start-up image", REG_OFS[i], REG_RST[i]);
      for (int i = 0; i < 8; i++) reg_wr(vofs[i], 8'h30 + 8'(i));
      for (int i = 0; i < 4; i++) begin
         check("buck voltage", vb[i], 8'h30 + 8'(i));
         check("linreg voltage", vl[i], 8'h34 + 8'(i));
      end
      reg_wr(8'hC5, 8'h5A);
      check("charge voltage", {4'h0, bv}, 8'h05);
      check("charge current", {4'h0, bi}, 8'h0A);
      reg_wr(8'hA6, 8'hFF);
      rd_chk("unmapped", 8'hA6, 8'h00);
      reg_wr(8'hF0, 8'h00);
      rd_chk("status read-only", 8'hF0, 8'hE3);
      i2c_start();
      wr_byte({ADDR ^ 7'h01, 1'b0}, ack);
      check("foreign address ack", {7'h00, ack}, 8'h00);
      check("data pin level", {7'h00, sda_do}, 8'h00);
      i2c_stop();
   endtask

   // Button press in active: reset at once, then descending slot order
   task automatic t_power_down();
      int fall [8];
      logic [7:0] prev;
      logic [7:0] cur;
      reg_wr(8'h82, 8'h00);
      prev = {bk_en, ldo_en};
      btn_n = 1'b0;
      repeat (10) @(negedge mclk);
      btn_n = 1'b1;
      check("reset on power-down", {7'h00, rst_n}, 8'h00);
      for (int n = 0; n < 25000 && prev != 8'h00; n++) begin
         @(negedge mclk);
         cur = {bk_en, ldo_en};
         for (int j = 0; j < 8; j++) if (prev[j] && !cur[j]) fall[j] = n;
         prev = cur;
      end
      check("all off", prev, 8'h00);
      for (int j = 7; j > 0; j--) begin
         check("descending order", {7'h00, fall[j] < fall[j - 1]}, 8'h01);
      end
      rd_chk("status off", 8'hF0, 8'h00);
   endtask

   // From powerdown a press starts up; slot zero keeps linreg4 off
   task automatic t_button_boot();
      reg_wr(8'h82, 8'h10);
      reg_wr(8'h84, 8'h03);
      reg_wr(8'h95, 8'h41);
      reg_wr(8'h96, 8'h0F);
      reg_wr(8'h99, 8'h05);
      @(negedge mclk);
      btn_n = 1'b0;
      rel0 = cyc;
      repeat (10) @(negedge mclk);
      btn_n = 1'b1;
      wait_until(2000);
      check("dummy slot", {4'h0, ldo_en}, 8'h00);
      wait_until(5800);
      check("linreg enables", {4'h0, ldo_en}, 8'h07);
      check("buck enables", {4'h0, bk_en}, 8'h00);
      check("reset before active", {7'h00, rst_n}, 8'h00);
      wait_until(8000);
      check("reset after active", {7'h00, rst_n}, 8'h01);
      check("linreg4 stays off", {4'h0, ldo_en}, 8'h07);
      rd_chk("status active", 8'hF0, 8'h43);
   endtask

   initial begin
      repeat (3) @(negedge mclk);
      srst = 1'b0;
      rel0 = cyc;
      check("reset output held", {7'h00, rst_n}, 8'h00);
      t_power_up();
      t_regs();
      t_power_down();
      t_button_boot();
      tally_and_finish();
   end
endmodule // pmic_power_sequence_config_tb_top
`default_nettype wire
